// *** verilog/sdi_video_serial_encoder.sv ***
`timescale 1ns/1ps
`include "sdi_enc_map.svh"

// Contract
// - capture 8- or 10-bit word each word clock, feed scrambler and detector
// - expand 8-bit words to 10 bits according to component, NTSC or PAL format
// - reference character detection only while active-low enable is low
// - detector marks valid video between recognised SAV and EAV words
// - reference characters 000h to 003h are forced to 000h
// - reference characters 3FCh to 3FFh are forced to 3FFh
// - clipping happens before the word enters the scrambler
// - serialise, then scramble the serial bits with x^9+x^4+1
// - convert the serial stream to NRZI with x+1
// - each word goes out least significant bit first
// - serial bit rate is ten times word clock, referenced to it only
// - lock indicator rises within 75 us of first word clock edge
// - lock indicator high while locked, low otherwise
// - serial output static while out of lock
// - reset clears detector, registers, counters and scrambler, disables output
// - serial pair held p low, n high with output enable low during power-on reset
// - stay in reset until word clock edges arrive
module sdi_video_serial_encoder
    import sdi_enc_pkg::*;
#(
    parameter int LOCK_CYC = `LOCK_CYCLES,
    parameter int IDLE_CYC = `LINK_IDLE_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_word_clk,
    input  wire logic [9:0]  i_parallel_word_in,
    input  wire logic        i_word_8bit,
    input  wire logic [1:0]  i_video_fmt,
    input  wire logic        i_sync_detect_en_n,
    output logic             o_serial_out_pair_p,
    output logic             o_serial_out_pair_n,
    output logic             o_serial_oe,
    output logic             o_lock,
    output logic             o_valid_video
);
    // two-flop synchronisers for pins
    logic [1:0]  wclk_sync_r;
    logic        wclk_prev_r;
    logic [9:0]  word_s1_r;
    logic [9:0]  word_s2_r;
    logic [3:0]  ctl_s1_r;
    logic [3:0]  ctl_s2_r;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wclk_sync_r <= 2'b11;                                  // preset: a clock high at release is no edge
            wclk_prev_r <= 1'b1;
            word_s1_r   <= 10'h000;
            word_s2_r   <= 10'h000;
            ctl_s1_r    <= 4'h0;
            ctl_s2_r    <= 4'h0;
        end else begin
            wclk_sync_r <= {wclk_sync_r[0], i_word_clk};
            wclk_prev_r <= wclk_sync_r[1];
            word_s1_r   <= i_parallel_word_in;
            word_s2_r   <= word_s1_r;
            ctl_s1_r    <= {i_sync_detect_en_n, i_word_8bit, i_video_fmt};
            ctl_s2_r    <= ctl_s1_r;
        end
    end

    // word clock rising edge and field decode
    wire        wclk_rise = wclk_sync_r[1] & ~wclk_prev_r;
    wire        det_en_n  = ctl_s2_r[3];
    wire        is_8bit   = ctl_s2_r[2];
    video_fmt_t fmt;
    assign fmt = video_fmt_t'(ctl_s2_r[1:0]);

    // 8-bit expansion: component and NTSC pad zeros, PAL sets low bits mid-scale
    logic [1:0] ext_lsb;
    always_comb begin
        unique case (fmt)
            FMT_COMPONENT: ext_lsb = 2'b00;
            FMT_NTSC:      ext_lsb = 2'b00;
            FMT_PAL:       ext_lsb = 2'b10;
            default:       ext_lsb = 2'b00;
        endcase
    end
    wire [9:0] word_ext = is_8bit ? {word_s2_r[9:2], ext_lsb} : word_s2_r;

    // input register, one word per word clock edge
    logic [9:0] in_word_r;
    logic       started_r;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            in_word_r <= 10'h000;
            started_r <= 1'b0;
        end else if (wclk_rise) begin
            in_word_r <= word_ext;
            started_r <= 1'b1;
        end
    end

    // reference character detection on unclipped input codes (in_word_r), ahead of the clip
    wire       is_low   = (in_word_r <= `TRS_LOW_MAX);
    wire       is_high  = (in_word_r >= `TRS_HIGH_MIN);
    logic [1:0] trs_cnt_r;                                         // 0: none, 1: ff seen, 2: ff 00 seen
    logic       valid_r;
    wire        trs_low_ok  = ~det_en_n & is_low & (trs_cnt_r != 2'd0);
    wire        trs_high_ok = ~det_en_n & is_high & (trs_cnt_r == 2'd0);
    wire        trs_xyz     = ~det_en_n & (trs_cnt_r == 2'd3);

    // clip recognised characters before scrambling
    wire [9:0] clip_word = trs_high_ok ? `TRS_HIGH_VAL :
                           trs_low_ok  ? `TRS_LOW_VAL  :
                           in_word_r;

    logic [9:0] word_r;
    logic       word_new_r;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            trs_cnt_r  <= 2'd0;
            valid_r    <= 1'b0;
            word_r     <= 10'h000;
            word_new_r <= 1'b0;
        end else begin
            word_new_r <= wclk_rise & started_r;
            if (wclk_rise && started_r) begin
                word_r <= clip_word;
                if (det_en_n) begin
                    trs_cnt_r <= 2'd0;
                end else if (trs_xyz) begin
                    trs_cnt_r <= 2'd0;
                    valid_r   <= ~in_word_r[6];
                end else if (trs_high_ok) begin
                    trs_cnt_r <= 2'd1;
                end else if (trs_low_ok) begin
                    trs_cnt_r <= trs_cnt_r + 2'd1;
                end else begin
                    trs_cnt_r <= 2'd0;
                end
            end
        end
    end
    assign o_valid_video = valid_r;

    // measure word period in clk cycles
    logic [15:0] per_cnt_r;
    logic [15:0] period_r;
    logic [15:0] acc_r;
    logic [3:0]  bit_idx_r;
    logic [9:0]  shift_r;
    logic        step_r;
    // ten bit slots spread evenly over one word period, no integer rounding
    wire  [16:0] acc_sum  = {1'b0, acc_r} + 17'(`BITS_PER_WORD);
    wire         slot_due = (acc_sum >= {1'b0, period_r});
    wire  [16:0] acc_wrap = acc_sum - {1'b0, period_r};
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            per_cnt_r <= 16'h0000;
            period_r  <= 16'h0000;
        end else if (wclk_rise) begin
            per_cnt_r <= 16'h0001;
            period_r  <= per_cnt_r;
        end else if (per_cnt_r != 16'hffff) begin
            per_cnt_r <= per_cnt_r + 16'h0001;
        end
    end

    // serialiser, lsb first, restarts each new word
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            acc_r     <= 16'h0000;
            bit_idx_r <= 4'h0;
            shift_r   <= 10'h000;
            step_r    <= 1'b0;
        end else if (word_new_r) begin
            acc_r     <= 16'h0000;
            bit_idx_r <= 4'h0;
            shift_r   <= word_r;
            step_r    <= 1'b1;
        end else begin
            step_r <= 1'b0;
            if (slot_due && (bit_idx_r < 4'd9)) begin
                acc_r     <= acc_wrap[15:0];
                bit_idx_r <= bit_idx_r + 4'h1;
                shift_r   <= {1'b0, shift_r[9:1]};
                step_r    <= 1'b1;
            end else begin
                acc_r <= acc_sum[15:0];
            end
        end
    end

    // lock machine: settle after first edge, drop when clock stops
    lock_state_t st_r;
    logic [31:0] lock_cnt_r;
    logic [15:0] idle_cnt_r;
    wire         clk_lost = (idle_cnt_r >= 16'(IDLE_CYC));
    wire         settle_done = (lock_cnt_r >= 32'(LOCK_CYC - 1));
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            idle_cnt_r <= 16'h0000;
        end else if (wclk_rise) begin
            idle_cnt_r <= 16'h0000;
        end else if (!clk_lost) begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r       <= ST_RESET;
            lock_cnt_r <= 32'h0000_0000;
        end else begin
            unique case (st_r)
                ST_RESET: begin
                    lock_cnt_r <= 32'h0000_0000;
                    if (wclk_rise) st_r <= ST_LOCK;
                end
                ST_LOCK: begin
                    lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
                    if (clk_lost) st_r <= ST_RESET;
                    else if (settle_done) st_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (clk_lost) st_r <= ST_RESET;
                end
                default: st_r <= ST_RESET;
            endcase
        end
    end
    wire locked = (st_r == ST_RUN);
    assign o_lock = locked;

    // scrambler and nrzi, steps only when locked
    logic nrzi;
    sdi_scrambler_nrzi u_scr (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_clear (~locked),
        .i_step  (step_r & locked),
        .i_bit   (shift_r[0]),
        .o_nrzi  (nrzi)
    );

    // output pair, static out of lock, enabled once clock seen
    assign o_serial_out_pair_p = locked ? nrzi : 1'b0;
    assign o_serial_out_pair_n = locked ? ~nrzi : 1'b1;
    assign o_serial_oe         = started_r;

    a_lock_timing : assert property (@(posedge i_clk) disable iff (i_reset)
        (st_r == ST_LOCK && settle_done && !clk_lost) |=> o_lock)
        else $error("lock did not rise after settle time");
    a_static_unlocked : assert property (@(posedge i_clk) disable iff (i_reset)
        (!o_lock && !$past(o_lock)) |-> $stable(o_serial_out_pair_p))
        else $error("serial output toggled while unlocked");
    a_oe_before_clock : assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_serial_oe) |-> $past(wclk_rise))
        else $error("output enabled before word clock");
    a_clip_high : assert property (@(posedge i_clk) disable iff (i_reset)
        (wclk_rise && started_r && trs_high_ok) |=> (word_r == `TRS_HIGH_VAL))
        else $error("high reference character not clipped");
    a_clip_low : assert property (@(posedge i_clk) disable iff (i_reset)
        (wclk_rise && started_r && trs_low_ok) |=> (word_r == `TRS_LOW_VAL))
        else $error("low reference character not clipped");
    a_detect_off : assert property (@(posedge i_clk) disable iff (i_reset)
        (det_en_n && wclk_rise && started_r) |=> (trs_cnt_r == 2'd0))
        else $error("detector ran while disabled");
    a_lsb_first : assert property (@(posedge i_clk) disable iff (i_reset)
        word_new_r |=> (shift_r[0] == $past(word_r[0])))
        else $error("first serial bit is not the lsb");
    a_capture_word : assert property (@(posedge i_clk) disable iff (i_reset)
        (wclk_rise && !is_8bit) |=> (in_word_r == $past(word_s2_r)))
        else $error("input word not captured");
endmodule : sdi_video_serial_encoder

// *** inc/sdi_enc_map.svh ***
`ifndef SDI_ENC_MAP_SVH
`define SDI_ENC_MAP_SVH

// word layout
`define WORD_W          10
`define TRS_LOW_MAX     10'h003
`define TRS_LOW_VAL     10'h000
`define TRS_HIGH_MIN    10'h3fc
`define TRS_HIGH_VAL    10'h3ff
// serial timing
`define BITS_PER_WORD   10
`define CLK_PERIOD_NS   10
`define LOCK_TIME_US    75
`define LOCK_CYCLES     ((`LOCK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define LINK_IDLE_CYC   64
// scrambler taps (x^9 + x^4 + 1)
`define SCR_TAP_A       8
`define SCR_TAP_B       3

`endif

// *** inc/sdi_enc_pkg.sv ***
package sdi_enc_pkg;
    typedef enum logic [1:0] {
        FMT_COMPONENT = 2'b00,
        FMT_NTSC      = 2'b01,
        FMT_PAL       = 2'b10,
        FMT_RESERVED  = 2'b11
    } video_fmt_t;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_LOCK   = 2'b01,
        ST_RUN    = 2'b10
    } lock_state_t;
endpackage : sdi_enc_pkg

// *** verilog/sdi_scrambler_nrzi.sv ***
`timescale 1ns/1ps
`include "sdi_enc_map.svh"

// one serial bit per step: x^9+x^4+1 scrambler then x+1 nrzi
module sdi_scrambler_nrzi (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_clear,
    input  wire logic i_step,
    input  wire logic i_bit,
    output logic      o_nrzi
);
    logic [8:0] scr_r;
    logic       nrzi_r;
    wire        scr_bit;

    // scrambled bit from input and delayed taps
    assign scr_bit = i_bit ^ scr_r[`SCR_TAP_A] ^ scr_r[`SCR_TAP_B];

    // shift history and toggle nrzi on each one
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            scr_r  <= 9'h000;
            nrzi_r <= 1'b0;
        end else if (i_clear) begin
            scr_r  <= 9'h000;
            nrzi_r <= 1'b0;
        end else if (i_step) begin
            scr_r  <= {scr_r[7:0], scr_bit};
            nrzi_r <= nrzi_r ^ scr_bit;
        end
    end

    assign o_nrzi = nrzi_r;

    a_nrzi_toggle_one : assert property (@(posedge i_clk) disable iff (i_reset)
        (i_step && !i_clear) |=> (nrzi_r == ($past(nrzi_r) ^ $past(scr_bit))))
        else $error("nrzi did not follow scrambled bit");
    a_scr_hold_idle : assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_step && !i_clear) |=> $stable(scr_r))
        else $error("scrambler moved without a step");
endmodule : sdi_scrambler_nrzi

// *** verif/video_source_model.sv ***
`timescale 1ns/1ps

// video source: word clock of 2*HALF clk periods, word changes on its falling edge
module video_source_model #(
    parameter int HALF = 10
) (
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic [9:0] i_word,
    output logic            o_word_clk,
    output logic [9:0]      o_word
);
    int cnt_r;

    initial begin
        o_word_clk = 1'b0;
        o_word = 10'h000;
        cnt_r = 0;
    end

    // clock stays low until run, so the device sees no edge early
    always @(posedge i_clk) begin
        if (!i_run) begin
            o_word_clk <= 1'b0;
            cnt_r <= 0;
        end else if (cnt_r == HALF - 1) begin
            cnt_r <= 0;
            o_word_clk <= ~o_word_clk;
            if (o_word_clk) begin
                o_word <= i_word;
            end
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule : video_source_model

// *** verif/test_sdi_video_serial_encoder.sv ***
`timescale 1ns/1ps

module test_sdi_video_serial_encoder
    import sdi_enc_pkg::*;
;
    localparam int LOCK = 50;
    localparam int IDLE = 64;
    typedef struct packed {
        logic [9:0] w;
        logic       b8;
        logic [1:0] fmt;
        logic [9:0] exp;
    } row_t;
    // inputs beside the word expected on the line
    row_t rows [5] = '{
        '{10'h00b, 1'b0, FMT_COMPONENT, 10'h00b},
        '{10'h02f, 1'b1, FMT_COMPONENT, 10'h02c},
        '{10'h02f, 1'b1, FMT_NTSC,      10'h02c},
        '{10'h02f, 1'b1, FMT_PAL,       10'h02e},
        '{10'h02f, 1'b1, FMT_RESERVED,  10'h02c}};
    logic        clk, rst, b8, en_n, run, sp, sn, oe, lock, valid;
    logic [1:0]  fmt;
    logic [9:0]  word, pword;
    logic        wclk, pprev, ph, seen, moved, s0;
    logic [8:0]  hist;
    logic [29:0] win, tgt;
    int          fail_count, total_checks, k, nb, nb0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    video_source_model #(.HALF(8)) src (.i_clk(clk), .i_run(run), .i_word(word), .o_word_clk(wclk), .o_word(pword));

    sdi_video_serial_encoder #(.LOCK_CYC(LOCK), .IDLE_CYC(IDLE)) uut (
        .i_clk(clk), .i_reset(rst), .i_word_clk(wclk), .i_parallel_word_in(pword), .i_word_8bit(b8),
        .i_video_fmt(fmt), .i_sync_detect_en_n(en_n), .o_serial_out_pair_p(sp), .o_serial_out_pair_n(sn),
        .o_serial_oe(oe), .o_lock(lock), .o_valid_video(valid));

    // bit strobe: the serial bit clock that a far-end receiver would recover
    always @(posedge clk) begin
        ph <= uut.u_scr.i_step;
    end

    // line monitor: undo nrzi and scrambler once per serial bit, bits enter window lsb first
    always @(negedge clk) begin
        if (ph) begin
            nb <= nb + 1;
            pprev <= sp;
            hist <= {hist[7:0], sp ^ pprev};
            win <= {sp ^ pprev ^ hist[3] ^ hist[8], win[29:1]};
        end
        if (win === tgt) begin
            seen <= 1'b1;
        end
    end

    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            $display("[ERR] %0t %s", $time, msg);
            fail_count++;
        end
    endtask : chk

    // bounded wait for a word clock rise, then hand over the next word
    task automatic send(input logic [9:0] w, input int n);
        int t;
        repeat (n) begin
            t = 0;
            while (wclk !== 1'b0 && t < 60) begin
                @(negedge clk);
                t++;
            end
            while (wclk !== 1'b1 && t < 60) begin
                @(negedge clk);
                t++;
            end
            if (t >= 60) begin
                chk(1'b0, "word clock stalled");
                summarize();
            end
            @(posedge clk);
            word <= w;
        end
    endtask : send

    // reference sequence 3fd 001 002 xyz amid filler words
    task automatic trs(input logic dis, input logic [9:0] xyz, input logic [29:0] t, input logic v);
        @(posedge clk);
        en_n <= dis;
        b8 <= 1'b0;
        send(10'h155, 4);
        tgt = t;
        seen = 1'b0;
        send(10'h3fd, 1);
        send(10'h001, 1);
        send(10'h002, 1);
        send(xyz, 1);
        send(10'h155, 6);
        @(negedge clk);
        chk(seen === 1'b1, "reference words wrong on line");
        chk(valid === v, "valid video flag wrong");
    endtask : trs

    task automatic wait_lock(input int lim);
        k = 0;
        moved = 1'b0;
        while (lock !== 1'b1 && k < lim) begin
            @(negedge clk);
            k++;
            moved = moved | (lock !== 1'b1 && sp !== 1'b0);
        end
    endtask : wait_lock

    // main sequence
    initial begin
        {rst, b8, en_n, run, pprev, ph, seen} = 7'h40;
        fmt = 2'b00;
        word = 10'h000;
        hist = 9'h000;
        win = 30'h0;
        tgt = 30'h0;
        fail_count = 0;
        nb = 0;
        nb0 = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        chk(oe === 1'b0 && lock === 1'b0 && sp === 1'b0 && sn === 1'b1, "outputs active in reset");
        rst <= 1'b0;
        repeat (30) @(negedge clk);
        chk(oe === 1'b0 && lock === 1'b0, "left reset without word clock");
        @(posedge clk);
        run <= 1'b1;
        send(10'h000, 1);
        wait_lock(LOCK + 20);
        chk(k >= LOCK - 4 && k <= LOCK + 6, "lock time off");
        chk(moved === 1'b0, "serial moved while unlocked");
        chk(oe === 1'b1, "serial not driven after clock");
        foreach (rows[i]) begin
            @(posedge clk);
            b8 <= rows[i].b8;
            fmt <= rows[i].fmt;
            send(rows[i].w, 4);
            tgt = {3{rows[i].exp}};
            seen = 1'b0;
            nb0 = nb;
            send(rows[i].w, 8);
            chk(seen === 1'b1, "word wrong on line");
            chk(nb - nb0 == 80, "not ten bits per word period");
            @(negedge clk);
            chk(sn === ~sp && oe === 1'b1, "serial pair not complementary");
        end
        trs(1'b0, 10'h200, 30'h0000003ff, 1'b1);
        trs(1'b0, 10'h240, 30'h0000003ff, 1'b0);
        trs(1'b0, 10'h200, 30'h0000003ff, 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        chk(oe === 1'b0 && lock === 1'b0 && valid === 1'b0 && sp === 1'b0 && sn === 1'b1, "reset mid-run");
        @(posedge clk);
        rst <= 1'b0;
        wait_lock(LOCK + 60);
        chk(lock === 1'b1 && moved === 1'b0, "no relock after reset");
        trs(1'b1, 10'h200, {10'h002, 10'h001, 10'h3fd}, 1'b0);
        @(posedge clk);
        run <= 1'b0;
        repeat (IDLE + 40) @(negedge clk);
        chk(lock === 1'b0, "lock held without word clock");
        s0 = sp;
        moved = 1'b0;
        repeat (40) begin
            @(negedge clk);
            moved = moved | (sp !== s0);
        end
        chk(moved === 1'b0, "serial toggles out of lock");
        summarize();
    end
endmodule : test_sdi_video_serial_encoder
